// ===== hdl/gpam_pkg.sv
package gpam_pkg;

  localparam int unsigned NPORT = 8;
  localparam int unsigned PW    = 8;
  localparam int unsigned NPIN  = NPORT * PW;

  // sub-register select codes held in the per-port address register
  localparam logic [7:0] SUB_DIR    = 8'h01;
  localparam logic [7:0] SUB_ALT    = 8'h02;
  localparam logic [7:0] SUB_OPEN   = 8'h03;
  localparam logic [7:0] SUB_HIDRV  = 8'h04;
  localparam logic [7:0] SUB_STOPRC = 8'h05;

  // register write target
  localparam logic [1:0] WR_ADDR = 2'h0;
  localparam logic [1:0] WR_CTL  = 2'h1;
  localparam logic [1:0] WR_OUT  = 2'h2;

  localparam logic [7:0] DIR_RESET = 8'hFF;

  // implemented pins per variant, flat {H,G,F,E,D,C,B,A}
  localparam logic [3:0][63:0] IMPL_MASK = '{
    64'h0FFF_FFFF_FFFF_FFFF,
    64'h0F08_80FF_FFFF_FFFF,
    64'h0000_0000_7FFF_FFFF,
    64'h0000_0000_7B7F_FFFF};

  // pins that own an alternate function per variant
  localparam logic [3:0][63:0] ALT_MASK = '{
    64'h0F00_0000_F3FF_FFFB,
    64'h0F00_0000_F3FF_FFFB,
    64'h0F00_0000_F0FF_FFFB,
    64'h0F00_0000_F0FF_FFFB};

  // pins whose alternate function is forced open-drain
  localparam logic [63:0] I2C_MASK = 64'h0000_0000_0000_00C0;

  // pins feeding peripheral inputs, in output port order
  localparam int unsigned NPIN_IN = 14;
  localparam logic [5:0] IN_PIN [NPIN_IN] = '{
    6'h00, 6'h03, 6'h04, 6'h06, 6'h07, 6'h10, 6'h12,
    6'h13, 6'h14, 6'h15, 6'h16, 6'h18, 6'h1C, 6'h1E};

  // pins driven by peripheral outputs
  localparam int unsigned NPIN_OUT = 12;
  localparam logic [5:0] OUT_PIN [NPIN_OUT] = '{
    6'h01, 6'h05, 6'h06, 6'h07, 6'h11, 6'h13,
    6'h14, 6'h15, 6'h17, 6'h19, 6'h1D, 6'h1F};

  typedef struct packed {
    logic [63:0]       sync1;
    logic [63:0]       sync2;
    logic [63:0]       prev;
    logic [63:0]       in_data;
    logic [63:0]       stop_ref;
    logic [7:0][7:0]   addr;
    logic [7:0][7:0]   dir;
    logic [7:0][7:0]   alt;
    logic [7:0][7:0]   odrain;
    logic [7:0][7:0]   hidrv;
    logic [7:0][7:0]   stoprc;
    logic [7:0][7:0]   outd;
    logic [63:0]       pin_out;
    logic [63:0]       pin_oe_n;
    logic [63:0]       pin_high_drive;
    logic [63:0]       irq_pulse;
    logic [13:0]       periph_in;
    logic [11:0]       adc_en;
    logic              stop_recover;
    logic [7:0]        rd_addr;
    logic [7:0]        rd_ctl;
    logic [7:0]        rd_in;
    logic [7:0]        rd_out;
  } gpam_state_s;

endpackage : gpam_pkg

// ===== hdl/gpam_port_top.sv
// Operation
// - seven 8-bit ports A-G plus 4-bit port H, each with control and data.
// - each pin sets direction, open-drain, drive and alternate function.
// - smaller variants implement a pin subset; smallest lacks C7, D7, D2, E-H.
// - per-pin alternate select picks plain I/O or the peripheral function.
// - with alternate selected, output functions drive the pin; only SPI C3-C5 take their output enable from the peripheral.
// - A4/A5 UART 0 receive and transmit, infrared capable.
// - A6/A7 I2C clock/data, forced open-drain when selected.
// - C0/C1 timer 1, C2-C5 SPI, C6/C7 timer 2 (C7 absent smallest).
// - D0/D1 timer 3, absent on two smallest variants; D2/D3 nothing.
// - D4/D5 UART 1 data, D6 UART 1 clear-to-send, D7 watchdog oscillator.
// - ports E, F, G have no alternate functions.
// - interrupt pins pulse on rising, falling, or both edges.
// - in stop mode with clock halted the port logic stays idle.
// - in halt mode the port logic runs normally.
// - direction 0 drives output data, 1 tri-states and samples; reset to 1.
// - address codes 01-05 pick dir, alt, open, drive, stop-recovery.
// - any level change on a recovery-enabled pin requests stop recovery.
`timescale 1ns/10ps
`default_nettype none

module gpam_port_top #(
  parameter int unsigned VARIANT = 3
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        clk_en,
  input  wire logic        stop_mode,
  input  wire logic        wr_en,
  input  wire logic [2:0]  wr_port,
  input  wire logic [1:0]  wr_kind,
  input  wire logic [7:0]  wr_data,
  input  wire logic [2:0]  rd_port,
  input  wire logic [63:0] pin_in,
  input  wire logic [63:0] irq_enable,
  input  wire logic [63:0] irq_falling,
  input  wire logic [63:0] irq_both,
  input  wire logic        timer0_output,
  input  wire logic        uart0_transmit,
  input  wire logic        i2c_scl_out,
  input  wire logic        i2c_sda_out,
  input  wire logic        timer1_output,
  input  wire logic        spi_sck_out,
  input  wire logic        spi_sck_oe,
  input  wire logic        spi_mosi_out,
  input  wire logic        spi_mosi_oe,
  input  wire logic        spi_miso_out,
  input  wire logic        spi_miso_oe,
  input  wire logic        timer2_output,
  input  wire logic        timer3_output,
  input  wire logic        uart1_transmit,
  input  wire logic        watchdog_osc_output,
  output logic [63:0]      pin_out,
  output logic [63:0]      pin_oe_n,
  output logic [63:0]      pin_high_drive,
  output logic [63:0]      irq_pulse,
  output logic             stop_recover,
  output logic [7:0]       rd_addr,
  output logic [7:0]       rd_ctl,
  output logic [7:0]       rd_in,
  output logic [7:0]       rd_out,
  output logic             timer0_input,
  output logic             uart0_clear_to_send,
  output logic             uart0_receive,
  output logic             i2c_scl_in,
  output logic             i2c_sda_in,
  output logic             timer1_input,
  output logic             spi_ss_in,
  output logic             spi_sck_in,
  output logic             spi_mosi_in,
  output logic             spi_miso_in,
  output logic             timer2_input,
  output logic             timer3_input,
  output logic             uart1_receive,
  output logic             uart1_clear_to_send,
  output logic [11:0]      adc_channel_en
);

  localparam logic [63:0] IMPL = gpam_pkg::IMPL_MASK[VARIANT];
  localparam logic [63:0] ALTP = gpam_pkg::ALT_MASK[VARIANT] & IMPL;

  gpam_pkg::gpam_state_s st;
  gpam_pkg::gpam_state_s next_st;

  // implemented bits of one port
  function automatic logic [7:0] port_mask(input logic [2:0] p);
    port_mask = IMPL[p*gpam_pkg::PW +: gpam_pkg::PW];
  endfunction : port_mask

  logic [63:0] rise;
  logic [63:0] fall;
  logic [63:0] act;
  logic [63:0] odr;
  logic [63:0] drv;
  logic [63:0] val;
  logic [63:0] af_val;
  logic [63:0] af_drv;
  logic [11:0] src_val;
  logic [11:0] src_oe;
  logic [7:0]  pm;

  always_comb begin
    next_st = st;
    pm      = port_mask(wr_port);
    // two-stage synchroniser, first stage feeds only the second
    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;
    next_st.prev  = st.sync2;
    // input data register is frozen in stop mode
    if (!stop_mode) begin
      next_st.in_data = st.sync2 & IMPL;
    end
    rise = st.sync2 & ~st.prev;
    fall = ~st.sync2 & st.prev;
    next_st.irq_pulse = {64{~stop_mode}} & irq_enable & IMPL &
                        ((irq_both & (rise | fall)) |
                         (~irq_both & irq_falling & fall) |
                         (~irq_both & ~irq_falling & rise));
    // recovery compares against the level held at stop entry
    if (!stop_mode) begin
      next_st.stop_ref = st.sync2;
    end
    next_st.stop_recover = stop_mode &
      (|((st.sync2 ^ st.stop_ref) & st.stoprc & IMPL));

    // register writes
    if (wr_en) begin
      case (wr_kind)
        gpam_pkg::WR_ADDR: next_st.addr[wr_port] = wr_data;
        gpam_pkg::WR_CTL: begin
          case (st.addr[wr_port])
            gpam_pkg::SUB_DIR:    next_st.dir[wr_port]    = wr_data | ~pm;
            gpam_pkg::SUB_ALT:    next_st.alt[wr_port]    = wr_data & pm;
            gpam_pkg::SUB_OPEN:   next_st.odrain[wr_port] = wr_data & pm;
            gpam_pkg::SUB_HIDRV:  next_st.hidrv[wr_port]  = wr_data & pm;
            gpam_pkg::SUB_STOPRC: next_st.stoprc[wr_port] = wr_data & pm;
            default: ;
          endcase
        end
        gpam_pkg::WR_OUT: next_st.outd[wr_port] = wr_data & pm;
        default: ;
      endcase
    end

    // alternate function selection only where a function exists
    act = st.alt & ALTP;
    src_val = {watchdog_osc_output, uart1_transmit, timer3_output,
               timer2_output, spi_miso_out, spi_mosi_out, spi_sck_out,
               timer1_output, i2c_sda_out, i2c_scl_out, uart0_transmit,
               timer0_output};
    src_oe  = {4'hF, spi_miso_oe, spi_mosi_oe, spi_sck_oe, 5'h1F};
    af_val = '0;
    af_drv = '0;
    for (int k = 0; k < gpam_pkg::NPIN_OUT; k++) begin
      af_val[gpam_pkg::OUT_PIN[k]] = src_val[k];
      af_drv[gpam_pkg::OUT_PIN[k]] = src_oe[k];
    end
    val = (act & af_val) | (~act & st.outd);
    drv = (act & af_drv) | (~act & ~st.dir);
    odr = st.odrain | (act & gpam_pkg::I2C_MASK);
    drv = drv & ~(odr & val);
    next_st.pin_out        = val & IMPL;
    next_st.pin_oe_n       = ~(drv & IMPL);
    next_st.pin_high_drive = st.hidrv & IMPL;

    for (int k = 0; k < gpam_pkg::NPIN_IN; k++) begin
      next_st.periph_in[k] = st.sync2[gpam_pkg::IN_PIN[k]] &
                             act[gpam_pkg::IN_PIN[k]];
    end
    next_st.adc_en = {act[59:56], act[15:8]};

    // registered read-back of the selected port
    next_st.rd_addr = st.addr[rd_port];
    next_st.rd_in   = st.in_data[rd_port*gpam_pkg::PW +: gpam_pkg::PW];
    next_st.rd_out  = st.outd[rd_port];
    case (st.addr[rd_port])
      gpam_pkg::SUB_DIR:    next_st.rd_ctl = st.dir[rd_port] &
                                             port_mask(rd_port);
      gpam_pkg::SUB_ALT:    next_st.rd_ctl = st.alt[rd_port];
      gpam_pkg::SUB_OPEN:   next_st.rd_ctl = st.odrain[rd_port];
      gpam_pkg::SUB_HIDRV:  next_st.rd_ctl = st.hidrv[rd_port];
      gpam_pkg::SUB_STOPRC: next_st.rd_ctl = st.stoprc[rd_port];
      default:              next_st.rd_ctl = 8'h00;
    endcase
  end

  // clock enable low freezes everything; halt keeps it high
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st          <= '0;
      st.dir      <= {gpam_pkg::NPORT{gpam_pkg::DIR_RESET}};
      st.pin_oe_n <= '1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign pin_out             = st.pin_out;
  assign pin_oe_n            = st.pin_oe_n;
  assign pin_high_drive      = st.pin_high_drive;
  assign irq_pulse           = st.irq_pulse;
  assign stop_recover        = st.stop_recover;
  assign rd_addr             = st.rd_addr;
  assign rd_ctl              = st.rd_ctl;
  assign rd_in               = st.rd_in;
  assign rd_out              = st.rd_out;
  assign timer0_input        = st.periph_in[0];
  assign uart0_clear_to_send = st.periph_in[1];
  assign uart0_receive       = st.periph_in[2];
  assign i2c_scl_in          = st.periph_in[3];
  assign i2c_sda_in          = st.periph_in[4];
  assign timer1_input        = st.periph_in[5];
  assign spi_ss_in           = st.periph_in[6];
  assign spi_sck_in          = st.periph_in[7];
  assign spi_mosi_in         = st.periph_in[8];
  assign spi_miso_in         = st.periph_in[9];
  assign timer2_input        = st.periph_in[10];
  assign timer3_input        = st.periph_in[11];
  assign uart1_receive       = st.periph_in[12];
  assign uart1_clear_to_send = st.periph_in[13];
  assign adc_channel_en      = st.adc_en;

endmodule : gpam_port_top

`default_nettype wire

// ===== test/gpam_port_props.sv
`timescale 1ns/10ps
`default_nettype none
module gpam_port_props (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        clk_en,
  input wire logic        stop_mode,
  input wire logic        wr_en,
  input wire logic [2:0]  wr_port,
  input wire logic [1:0]  wr_kind,
  input wire logic [7:0]  wr_data,
  input wire logic [2:0]  rd_port,
  input wire logic [63:0] pin_in,
  input wire logic [63:0] irq_enable,
  input wire logic [63:0] irq_falling,
  input wire logic [63:0] irq_both,
  input wire logic [63:0] pin_out,
  input wire logic [63:0] pin_oe_n,
  input wire logic [63:0] irq_pulse,
  input wire logic        stop_recover,
  input wire logic [7:0]  rd_addr,
  input wire logic [11:0] adc_channel_en
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  chk_reset_state: assert property (
    $rose(nrst) |-> (&pin_oe_n) && pin_out == 64'h0 && irq_pulse == 64'h0)
    else $error("outputs not at reset values");
  chk_unimpl_pins: assert property (
    (&pin_oe_n[63:60]) && irq_pulse[63:60] == 4'h0)
    else $error("missing port h pin active");
  chk_addr_readback: assert property (
    clk_en && wr_en && wr_kind == gpam_pkg::WR_ADDR && wr_port == rd_port
    && wr_port != 3'h7 ##1 clk_en && !wr_en && $stable(rd_port)
    |=> rd_addr == $past(wr_data, 2)) else $error("address read-back wrong");
  chk_clock_freeze: assert property (
    !clk_en |=> $stable(pin_out) && $stable(pin_oe_n) && $stable(irq_pulse))
    else $error("outputs moved with clock halted");
  chk_stop_noirq: assert property (
    stop_mode && $past(stop_mode) |-> irq_pulse == 64'h0)
    else $error("interrupt raised in stop mode");
  chk_recover_cause: assert property (
    stop_recover |-> $past(stop_mode)) else $error("recovery outside stop");
  chk_irq_enabled: assert property (
    irq_pulse[16] |-> $past(irq_enable[16])) else $error("masked interrupt");
  chk_irq_rising: assert property (
    irq_pulse[16] && !irq_both[16] && !irq_falling[16]
    |-> $past(pin_in[16], 3))
    else $error("rising interrupt without high input");
  chk_adc_nodrive: assert property (
    adc_channel_en[0] && $past(adc_channel_en[0]) |-> pin_oe_n[8])
    else $error("analog pin driven");
  cover property (irq_pulse[16]);
  cover property (stop_recover);
  cover property (adc_channel_en[8] && !clk_en);
endmodule : gpam_port_props
bind gpam_port_top gpam_port_props i_gpam_port_props (
  .clk_sys, .nrst, .clk_en, .stop_mode, .wr_en, .wr_port, .wr_kind, .wr_data,
  .rd_port, .pin_in, .irq_enable, .irq_falling, .irq_both, .pin_out,
  .pin_oe_n, .irq_pulse, .stop_recover, .rd_addr, .adc_channel_en);
`default_nettype wire

// ===== test/gpam_board_model.sv
`timescale 1ns/10ps
`default_nettype none
module gpam_board_model (
  input  wire logic [63:0] pin_out,
  input  wire logic [63:0] pin_oe_n,
  input  wire logic [63:0] ext_lvl,
  output logic [63:0]      pin_in
);
  // a driven pin reads its own value back, a released one the board level
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule : gpam_board_model
`default_nettype wire

// ===== test/gpam_port_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module gpam_port_top_tb;
  logic        clk_sys, nrst, clk_en, stop_mode, wr_en, stop_recover;
  logic [2:0]  wr_port, rd_port;
  logic [1:0]  wr_kind;
  logic [7:0]  wr_data, rd_addr, rd_ctl, rd_in, rd_out;
  logic [63:0] pin_in, irq_enable, irq_falling, irq_both, ext_lvl;
  logic [63:0] pin_out, pin_oe_n, pin_high_drive, irq_pulse;
  logic [11:0] adc_channel_en;
  logic timer0_output, uart0_transmit, i2c_scl_out, i2c_sda_out, timer1_output;
  logic spi_sck_out, spi_sck_oe, spi_mosi_out, spi_mosi_oe, spi_miso_out;
  logic spi_miso_oe, timer2_output, timer3_output, uart1_transmit;
  logic watchdog_osc_output, timer0_input, uart0_clear_to_send, uart0_receive;
  logic i2c_scl_in, i2c_sda_in, timer1_input, spi_ss_in, spi_sck_in;
  logic spi_mosi_in, spi_miso_in, timer2_input, timer3_input, uart1_receive;
  logic uart1_clear_to_send;
  int   n_mismatch, n_checks;
  logic [7:0]  n;

  gpam_port_top #(.VARIANT(3)) i_gpam_port_top (
    .clk_sys, .nrst, .clk_en, .stop_mode, .wr_en, .wr_port, .wr_kind, .wr_data,
    .rd_port, .pin_in, .irq_enable, .irq_falling, .irq_both, .timer0_output,
    .uart0_transmit, .i2c_scl_out, .i2c_sda_out, .timer1_output, .spi_sck_out,
    .spi_sck_oe, .spi_mosi_out, .spi_mosi_oe, .spi_miso_out, .spi_miso_oe,
    .timer2_output, .timer3_output, .uart1_transmit, .watchdog_osc_output,
    .pin_out, .pin_oe_n, .pin_high_drive, .irq_pulse, .stop_recover, .rd_addr,
    .rd_ctl, .rd_in, .rd_out, .timer0_input, .uart0_clear_to_send,
    .uart0_receive, .i2c_scl_in, .i2c_sda_in, .timer1_input, .spi_ss_in,
    .spi_sck_in, .spi_mosi_in, .spi_miso_in, .timer2_input, .timer3_input,
    .uart1_receive, .uart1_clear_to_send, .adc_channel_en);
  gpam_board_model i_gpam_board_model (.pin_out, .pin_oe_n, .ext_lvl, .pin_in);

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic w(input int k);
    repeat (k) @(negedge clk_sys);
  endtask : w
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] p, input logic [1:0] k,
                    input logic [7:0] d);
    w(1);
    wr_en = 1'b1;
    {wr_port, wr_kind, wr_data} = {p, k, d};
    w(1);
    wr_en = 1'b0;
  endtask : wr
  task automatic set(input logic [2:0] p, input logic [7:0] a,
                     input logic [7:0] d);
    wr(p, gpam_pkg::WR_ADDR, a);
    wr(p, gpam_pkg::WR_CTL, d);
  endtask : set
  task automatic cnt_irq;
    n = 8'h00;
    repeat (8) begin
      w(1);
      n = n + {7'h00, irq_pulse[16]};
    end
  endtask : cnt_irq
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    {nrst, stop_mode, wr_en, wr_port, wr_kind, wr_data, rd_port} = '0;
    {irq_enable, irq_falling, irq_both, ext_lvl} = '0;
    clk_en = 1'b1;
    {timer0_output, uart0_transmit, i2c_scl_out, i2c_sda_out, timer1_output,
     spi_sck_out, spi_sck_oe, spi_mosi_out, spi_mosi_oe, spi_miso_out,
     spi_miso_oe, timer2_output, timer3_output, uart1_transmit,
     watchdog_osc_output} = 15'h0;
    w(20);
    nrst = 1'b1;
    wr(3'h0, gpam_pkg::WR_ADDR, gpam_pkg::SUB_DIR);
    w(3);
    chk(rd_ctl, gpam_pkg::DIR_RESET);
    chk(pin_oe_n, 64'hFFFF_FFFF_FFFF_FFFF);
    $display("done reset");
    rd_port = 3'h6;
    for (int c = 1; c < 6; c++) set(3'h6, 8'(c), 8'h30 + 8'(c));
    set(3'h6, 8'h06, 8'h00);
    for (int c = 1; c < 6; c++) begin
      wr(3'h6, gpam_pkg::WR_ADDR, 8'(c));
      w(3);
      chk(rd_ctl, 8'h30 + 8'(c));
    end
    chk(pin_high_drive[55:48], 8'h34);
    $display("done sub-registers");
    rd_port = 3'h0;
    set(3'h0, gpam_pkg::SUB_DIR, 8'hFE);
    wr(3'h0, gpam_pkg::WR_OUT, 8'h01);
    w(4);
    chk(rd_in[0], 1'b0);
    w(3);
    chk({pin_oe_n[7:0], pin_out[0], rd_in[0], rd_out}, 18'h3_FB01);
    ext_lvl[0] = 1'b1;
    timer0_output = 1'b1;
    uart0_transmit = 1'b1;
    set(3'h0, gpam_pkg::SUB_ALT, 8'hE3);
    w(6);
    chk({pin_oe_n[5], pin_out[5], pin_oe_n[1:0], pin_out[1], timer0_input},
        6'h17);
    i2c_scl_out = 1'b1;
    w(3);
    chk(pin_oe_n[6], 1'b1);
    i2c_scl_out = 1'b0;
    w(3);
    chk({pin_oe_n[6], pin_out[6]}, 2'h0);
    spi_sck_out = 1'b1;
    spi_sck_oe = 1'b1;
    timer3_output = 1'b1;
    watchdog_osc_output = 1'b1;
    ext_lvl[20] = 1'b1;
    ext_lvl[24] = 1'b1;
    set(3'h2, gpam_pkg::SUB_ALT, 8'h38);
    set(3'h3, gpam_pkg::SUB_ALT, 8'h83);
    set(3'h4, gpam_pkg::SUB_ALT, 8'hFF);
    w(6);
    chk({pin_oe_n[21:19], pin_out[19], spi_mosi_in, spi_sck_in}, 6'h37);
    chk({pin_oe_n[31], pin_oe_n[25], pin_out[31], pin_out[25], timer3_input,
         pin_oe_n[39:32]}, 13'h07FF);
    $display("done alternate functions");
    rd_port = 3'h7;
    set(3'h7, gpam_pkg::SUB_DIR, 8'h00);
    w(3);
    chk({rd_ctl, pin_oe_n[63:56]}, 16'h00F0);
    set(3'h1, gpam_pkg::SUB_ALT, 8'h01);
    set(3'h7, gpam_pkg::SUB_ALT, 8'h01);
    w(4);
    chk({adc_channel_en, pin_oe_n[8], pin_oe_n[56]}, 14'h0407);
    $display("done analog and missing pins");
    irq_enable[16] = 1'b1;
    for (int m = 0; m < 3; m++) begin
      {irq_falling[16], irq_both[16]} = {m == 1, m == 2};
      ext_lvl[16] = 1'b1;
      cnt_irq();
      chk(n, m != 1);
      ext_lvl[16] = 1'b0;
      cnt_irq();
      chk(n, m != 0);
    end
    $display("done interrupts");
    set(3'h4, gpam_pkg::SUB_STOPRC, 8'h01);
    stop_mode = 1'b1;
    w(3);
    chk(stop_recover, 1'b0);
    ext_lvl[32] = 1'b1;
    ext_lvl[16] = 1'b1;
    for (int i = 0; i < 10 && stop_recover !== 1'b1; i++) w(1);
    chk(stop_recover, 1'b1);
    if (stop_recover !== 1'b1) wrap_up();
    cnt_irq();
    chk(n, 0);
    clk_en = 1'b0;
    timer0_output = 1'b0;
    w(3);
    chk(pin_out[1], 1'b1);
    clk_en = 1'b1;
    stop_mode = 1'b0;
    w(3);
    chk(pin_out[1], 1'b0);
    $display("done stop and halt");
    wrap_up();
  end
endmodule : gpam_port_top_tb
`default_nettype wire
